// ---- src/login_pkg.sv ----
// constants, register map and carrier types of the login parameter codec
package login_pkg;
  // apb slave register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EXTLEN = 8'h04;
  localparam logic [7:0] OFS_BB = 8'h08;
  localparam logic [7:0] OFS_SEQ = 8'h0c;
  localparam logic [7:0] OFS_RATOV = 8'h10;
  localparam logic [7:0] OFS_EDTOV = 8'h14;
  localparam logic [7:0] OFS_PNAME_HI = 8'h18;
  localparam logic [7:0] OFS_PNAME_LO = 8'h1c;
  localparam logic [7:0] OFS_NNAME_HI = 8'h20;
  localparam logic [7:0] OFS_NNAME_LO = 8'h24;
  localparam logic [7:0] OFS_FNAME_HI = 8'h28;
  localparam logic [7:0] OFS_FNAME_LO = 8'h2c;
  localparam logic [7:0] OFS_CONC = 8'h30;
  localparam logic [7:0] OFS_REQ_EDTOV = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_MASK = 8'h3c;
  localparam logic [7:0] OFS_RX_W1 = 8'h40;
  localparam logic [7:0] OFS_EFF = 8'h44;
  localparam logic [7:0] OFS_EFF_EDTOV = 8'h48;
  // control bits
  localparam int CT_START = 0;
  localparam int CT_LEN_FLAG = 1;
  localparam int CT_ACCEPT = 2;
  localparam int CT_FABRIC_ACC = 3;
  localparam int CT_LPI = 4;
  localparam int CT_EDTOV_NS = 5;
  localparam int CT_PEER_SHORT = 6;
  localparam int CT_LOGIN_DONE = 7;
  // status and mask bits
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_PERR = 2;
  localparam int ST_W = 3;
  // payload length
  localparam int SHORT_BYTES = 116;
  localparam int LONG_BASE_BYTES = 256;
  localparam logic [9:0] SHORT_WORDS = 10'(SHORT_BYTES / 4);
  localparam logic [9:0] LONG_BASE_WORDS = 10'(LONG_BASE_BYTES / 4);
  // common word 1 fields
  localparam int W1_EDTOV_RES = 26;
  localparam int W1_LPI = 25;
  localparam int W1_LEN_FLAG = 16;
  localparam int W1_BBSC_LO = 12;
  localparam int W1_RXSZ_HI = 11;
  localparam logic [11:0] RXSZ_MIN = 12'h100;
  localparam logic [11:0] RXSZ_MAX = 12'h840;
  // payload word indices
  localparam logic [9:0] W_CMN1 = 10'h001;
  localparam logic [9:0] W_CMN2 = 10'h002;
  localparam logic [9:0] W_RATOV = 10'h003;
  localparam logic [9:0] W_EDTOV = 10'h004;
  localparam logic [9:0] W_PNAME_HI = 10'h005;
  localparam logic [9:0] W_PNAME_LO = 10'h006;
  localparam logic [9:0] W_NAME_HI = 10'h007;
  localparam logic [9:0] W_NAME_LO = 10'h008;
  localparam logic [9:0] W_CLS2 = 10'h00d;
  localparam logic [9:0] W_CLS3 = 10'h011;
  localparam logic [9:0] CLS_CONC_WORD = 10'h003;
  localparam int CLS_VALID_BIT = 31;
  localparam int CONC_LO = 16;
  localparam int NAME_FMT_LO = 28;
  // class validity before login completes
  localparam logic CLS_VALID_DEFAULT = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } word_s;
endpackage

// ---- src/login_param_codec.sv ----
// login service parameter payload builder and checker with apb registers
// Function
// - flag clear: payload is exactly 116 bytes.
// - flag set: payload is 256 plus four times extension length bytes.
// - accept to a short-payload login also clears its length flag.
// - word 1 bits 15-12 carry the credit recovery spacing exponent.
// - word 1 bits 11-0 carry receive data field size, multiple of four.
// - receive data field sizes below 256 or above 2112 are invalid.
// - word 1 bit 25 flags low-power-idle support.
// - total concurrent sequences must not exceed per-class sum.
// - word 2 bits 15-0 flag relative offset per information category.
// - resource allocation timeout counted in 1 ms units.
// - error detect timeout in ms, or ns when word 1 bit 26 set.
// - accept error detect timeout not below request; accept value used.
// - port name in words 5-6, top four bits give format.
// - node or fabric name in words 7-8, top four bits format.
// - fabric accept carries fabric name; other frames carry node name.
// - class 2 parameters in words 13-16, class 3 in 17-20.
// - before login completes, default class values apply.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module login_param_codec (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire login_pkg::apb_req_s apb_req,
  output login_pkg::apb_rsp_s apb_rsp,
  // outgoing payload words
  output login_pkg::word_s tx_word,
  input wire logic tx_ready,
  // incoming payload words
  input wire login_pkg::word_s rx_word,
  // interrupt
  output logic irq
);
  import login_pkg::*;

  typedef struct packed {
    tx_state_e st;
    logic [7:0] ctrl;
    logic [7:0] ext_len;
    logic [15:0] bb;
    logic [23:0] seqw;
    logic [31:0] ratov;
    logic [31:0] edtov;
    logic [63:0] pname;
    logic [63:0] nname;
    logic [63:0] fname;
    logic [15:0] conc;
    logic [31:0] req_edtov;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [9:0] tx_cnt;
    logic [9:0] tx_len;
    logic tx_flag;
    logic sent_short;
    logic [9:0] rx_cnt;
    logic [31:0] rx_w1;
    logic [31:0] rx_w2;
    logic [31:0] rx_edtov;
    logic [3:0] rx_pfmt;
    logic [1:0] rx_cls_valid;
    logic [15:0] rx_conc;
    logic [31:0] eff_edtov;
    logic eff_res;
    logic [1:0] eff_cls_valid;
    apb_rsp_s rsp;
    word_s tx;
    logic irq;
  } state_s;

  state_s q;
  state_s n;

  // one payload word from the local settings
  function automatic logic [31:0] build_word(input state_s s, input logic [9:0] idx);
    logic [31:0] w;
    logic [31:0] ed;
    w = 32'h0;
    ed = (s.ctrl[CT_ACCEPT] && s.req_edtov > s.edtov) ? s.req_edtov : s.edtov;
    unique case (idx)
      W_CMN1: begin
        w[W1_EDTOV_RES] = s.ctrl[CT_EDTOV_NS];
        w[W1_LPI] = s.ctrl[CT_LPI];
        w[W1_LEN_FLAG] = s.tx_flag;
        w[W1_BBSC_LO+3:0] = s.bb;
      end
      W_CMN2: w = {8'h0, s.seqw};
      W_RATOV: w = s.ratov;
      W_EDTOV: w = ed;
      W_PNAME_HI: w = s.pname[63:32];
      W_PNAME_LO: w = s.pname[31:0];
      W_NAME_HI: w = s.ctrl[CT_FABRIC_ACC] ? s.fname[63:32] : s.nname[63:32];
      W_NAME_LO: w = s.ctrl[CT_FABRIC_ACC] ? s.fname[31:0] : s.nname[31:0];
      W_CLS2: w[CLS_VALID_BIT] = 1'b1;
      W_CLS2 + CLS_CONC_WORD: w[CONC_LO+7:CONC_LO] = s.conc[7:0];
      W_CLS3: w[CLS_VALID_BIT] = 1'b1;
      W_CLS3 + CLS_CONC_WORD: w[CONC_LO+7:CONC_LO] = s.conc[15:8];
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  // next state: apb, builder, checker and interrupt
  always_comb begin
    logic acc;
    logic wr;
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] clr;
    logic [11:0] sz;
    logic [9:0] exp_len;
    logic bad;
    logic [31:0] rd;
    logic hit;
    acc = apb_req.psel && apb_req.penable;
    wr = acc && q.rsp.pready && apb_req.pwrite;
    set = '0;
    clr = '0;
    sz = 12'h0;
    exp_len = 10'h0;
    bad = 1'b0;
    rd = 32'h0;
    hit = 1'b1;
    n = q;
    // one wait state, then a single-cycle ready
    n.rsp.pready = acc && !q.rsp.pready;
    unique case (apb_req.paddr)
      OFS_CTRL: rd = {24'h0, q.ctrl};
      OFS_EXTLEN: rd = {24'h0, q.ext_len};
      OFS_BB: rd = {16'h0, q.bb};
      OFS_SEQ: rd = {8'h0, q.seqw};
      OFS_RATOV: rd = q.ratov;
      OFS_EDTOV: rd = q.edtov;
      OFS_PNAME_HI: rd = q.pname[63:32];
      OFS_PNAME_LO: rd = q.pname[31:0];
      OFS_NNAME_HI: rd = q.nname[63:32];
      OFS_NNAME_LO: rd = q.nname[31:0];
      OFS_FNAME_HI: rd = q.fname[63:32];
      OFS_FNAME_LO: rd = q.fname[31:0];
      OFS_CONC: rd = {16'h0, q.conc};
      OFS_REQ_EDTOV: rd = q.req_edtov;
      OFS_STATUS: rd = {29'h0, q.status};
      OFS_MASK: rd = {29'h0, q.mask};
      OFS_RX_W1: rd = q.rx_w1;
      OFS_EFF: rd = {25'h0, q.rx_pfmt, q.eff_cls_valid, q.eff_res};
      OFS_EFF_EDTOV: rd = q.eff_edtov;
      default: hit = 1'b0;
    endcase
    if (acc && !q.rsp.pready) begin
      n.rsp.prdata = apb_req.pwrite ? 32'h0 : rd;
      n.rsp.pslverr = !hit;
    end
    // writes land at the edge that sees pready high
    if (wr) begin
      unique case (apb_req.paddr)
        OFS_CTRL: n.ctrl = {apb_req.pwdata[7:1], 1'b0};
        OFS_EXTLEN: n.ext_len = apb_req.pwdata[7:0];
        OFS_BB: n.bb = apb_req.pwdata[15:0];
        OFS_SEQ: n.seqw = apb_req.pwdata[23:0];
        OFS_RATOV: n.ratov = apb_req.pwdata;
        OFS_EDTOV: n.edtov = apb_req.pwdata;
        OFS_PNAME_HI: n.pname[63:32] = apb_req.pwdata;
        OFS_PNAME_LO: n.pname[31:0] = apb_req.pwdata;
        OFS_NNAME_HI: n.nname[63:32] = apb_req.pwdata;
        OFS_NNAME_LO: n.nname[31:0] = apb_req.pwdata;
        OFS_FNAME_HI: n.fname[63:32] = apb_req.pwdata;
        OFS_FNAME_LO: n.fname[31:0] = apb_req.pwdata;
        OFS_CONC: n.conc = apb_req.pwdata[15:0];
        OFS_REQ_EDTOV: n.req_edtov = apb_req.pwdata;
        OFS_STATUS: clr = apb_req.pwdata[ST_W-1:0];
        OFS_MASK: n.mask = apb_req.pwdata[ST_W-1:0];
        default: n.mask = q.mask;
      endcase
    end
    // builder: start bit is a pulse, ignored while a payload is going out
    unique case (q.st)
      ST_IDLE: begin
        if (wr && apb_req.paddr == OFS_CTRL && apb_req.pwdata[CT_START]) begin
          n.st = ST_SEND;
          // an accept to a short login must stay short
          n.tx_flag = apb_req.pwdata[CT_LEN_FLAG] &&
                      !(apb_req.pwdata[CT_ACCEPT] && apb_req.pwdata[CT_PEER_SHORT]);
          n.tx_len = n.tx_flag ? LONG_BASE_WORDS + {2'b00, q.ext_len} : SHORT_WORDS;
          n.tx_cnt = 10'h0;
          n.sent_short = !apb_req.pwdata[CT_ACCEPT] && !n.tx_flag;
          if (apb_req.pwdata[CT_ACCEPT]) begin
            // old ctrl is still in q here, so the larger value is picked directly
            n.eff_edtov = (q.req_edtov > q.edtov) ? q.req_edtov : q.edtov;
            n.eff_res = apb_req.pwdata[CT_EDTOV_NS];
          end
        end
      end
      ST_SEND: begin
        if (!q.tx.valid || tx_ready) begin
          if (q.tx.valid && q.tx.last) begin
            n.tx.valid = 1'b0;
            n.tx.last = 1'b0;
            n.st = ST_IDLE;
            set[ST_TX_DONE] = 1'b1;
          end else begin
            n.tx.valid = 1'b1;
            n.tx.data = build_word(q, q.tx_cnt);
            n.tx.last = (q.tx_cnt == q.tx_len - 10'h1);
            n.tx_cnt = q.tx_cnt + 10'h1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // checker: capture fields by word position
    if (rx_word.valid) begin
      unique case (q.rx_cnt)
        W_CMN1: n.rx_w1 = rx_word.data;
        W_CMN2: n.rx_w2 = rx_word.data;
        W_EDTOV: n.rx_edtov = rx_word.data;
        W_PNAME_HI: n.rx_pfmt = rx_word.data[NAME_FMT_LO+3:NAME_FMT_LO];
        W_CLS2: n.rx_cls_valid[0] = rx_word.data[CLS_VALID_BIT];
        W_CLS3: n.rx_cls_valid[1] = rx_word.data[CLS_VALID_BIT];
        W_CLS2 + CLS_CONC_WORD: n.rx_conc[7:0] = rx_word.data[CONC_LO+7:CONC_LO];
        W_CLS3 + CLS_CONC_WORD: n.rx_conc[15:8] = rx_word.data[CONC_LO+7:CONC_LO];
        default: n.rx_cnt = q.rx_cnt;
      endcase
      n.rx_cnt = q.rx_cnt + 10'h1;
      if (rx_word.last) begin
        sz = n.rx_w1[W1_RXSZ_HI:0];
        exp_len = n.rx_w1[W1_LEN_FLAG] ? LONG_BASE_WORDS + {2'b00, q.ext_len} : SHORT_WORDS;
        bad = (sz < RXSZ_MIN) || (sz > RXSZ_MAX) || (sz[1:0] != 2'b00);
        bad = bad || (n.rx_cnt != exp_len);
        bad = bad || ({1'b0, n.rx_w2[CONC_LO+7:CONC_LO]} >
                      ({1'b0, n.rx_conc[7:0]} + {1'b0, n.rx_conc[15:8]}));
        bad = bad || (q.sent_short && n.rx_w1[W1_LEN_FLAG]);
        bad = bad || (!q.ctrl[CT_ACCEPT] && n.rx_edtov < q.edtov);
        if (!q.ctrl[CT_ACCEPT]) begin
          // requester adopts the value carried by the accept
          n.eff_edtov = n.rx_edtov;
          n.eff_res = n.rx_w1[W1_EDTOV_RES];
        end
        n.rx_cnt = 10'h0;
        set[ST_RX_DONE] = 1'b1;
        set[ST_PERR] = bad;
      end
    end
    // defaults hold until software marks the login complete
    n.eff_cls_valid = q.ctrl[CT_LOGIN_DONE] ? q.rx_cls_valid : {2{CLS_VALID_DEFAULT}};
    // sticky status, a new event wins over a same-cycle clear
    n.status = (q.status & ~clr) | set;
    n.irq = |(n.status & n.mask);
    irq = q.irq;
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.tx_len <= SHORT_WORDS;
    end else begin
      q <= n;
    end
  end

  assign apb_rsp = q.rsp;
  assign tx_word = q.tx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_access_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence s_ready_once;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence

  property p_apb_answer;
    s_access_wait |=> s_ready_once;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not after one wait");

  property p_short_len;
    tx_word.valid && tx_word.last && !q.tx_flag |-> q.tx_cnt == SHORT_WORDS;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short payload length wrong");

  property p_long_len;
    tx_word.valid && tx_word.last && q.tx_flag |-> q.tx_cnt == LONG_BASE_WORDS + {2'b00, q.ext_len};
  endproperty
  a_long_len: assert property (p_long_len) else $error("long payload length wrong");

  // start write that must produce a short accept
  logic wr_start_short;
  assign wr_start_short = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
                          apb_req.paddr == OFS_CTRL && apb_req.pwdata[CT_START] &&
                          apb_req.pwdata[CT_ACCEPT] && apb_req.pwdata[CT_PEER_SHORT];
  property p_accept_short;
    q.st == ST_IDLE && wr_start_short |=> !q.tx_flag;
  endproperty
  a_accept_short: assert property (p_accept_short) else $error("accept to short login set flag");

  property p_flag_word1;
    tx_word.valid && q.tx_cnt == W_CMN1 + 10'h1 |-> tx_word.data[W1_LEN_FLAG] == q.tx_flag
      && tx_word.data[W1_LPI] == q.ctrl[CT_LPI];
  endproperty
  a_flag_word1: assert property (p_flag_word1) else $error("word 1 flags wrong");

  property p_name_sel;
    tx_word.valid && q.tx_cnt == W_NAME_HI + 10'h1 |->
      tx_word.data == (q.ctrl[CT_FABRIC_ACC] ? q.fname[63:32] : q.nname[63:32]);
  endproperty
  a_name_sel: assert property (p_name_sel) else $error("wrong name in words 7-8");

  property p_edtov_min;
    tx_word.valid && q.tx_cnt == W_EDTOV + 10'h1 && q.ctrl[CT_ACCEPT] |-> tx_word.data >= q.req_edtov;
  endproperty
  a_edtov_min: assert property (p_edtov_min) else $error("accept timeout below request");

  property p_bad_size;
    rx_word.valid && rx_word.last && q.rx_cnt != W_CMN1 &&
      (q.rx_w1[W1_RXSZ_HI:0] < RXSZ_MIN || q.rx_w1[W1_RXSZ_HI:0] > RXSZ_MAX) |=> q.status[ST_PERR];
  endproperty
  a_bad_size: assert property (p_bad_size) else $error("bad receive size not flagged");

  // a short payload of the wrong word count must raise the parameter error
  property p_len_err;
    rx_word.valid && rx_word.last && !q.rx_w1[W1_LEN_FLAG] && q.rx_cnt != W_CMN1 &&
      q.rx_cnt + 10'h1 != SHORT_WORDS |=> q.status[ST_PERR];
  endproperty
  a_len_err: assert property (p_len_err) else $error("payload length error not flagged");

  // receive size not a whole number of words is refused
  property p_size_align;
    rx_word.valid && rx_word.last && q.rx_cnt != W_CMN1 && q.rx_w1[1:0] != 2'b00 |=> q.status[ST_PERR];
  endproperty
  a_size_align: assert property (p_size_align) else $error("unaligned receive size not flagged");

  property p_irq;
    ##1 irq == $past(|(n.status & n.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");
endmodule // login_param_codec
`default_nettype wire

// ---- test/remote_port.sv ----
// far-side login port model: payload sink with optional stalls and payload source
`timescale 1ns/1ns
`default_nettype none
module remote_port (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // payload from the controller
  input wire login_pkg::word_s tx_word,
  output logic tx_ready,
  // payload to the controller
  output login_pkg::word_s rx_word,
  // bench control
  input wire logic stall
);
  import login_pkg::*;
  logic [31:0] cap [0:255];
  logic [31:0] rxbuf [0:127];
  int ncap;
  logic [1:0] pace;
  initial begin
    rx_word = '0;
  end
  // sink: when stalling, ready one cycle in three, like a busy peer
  always @(posedge clk) begin
    if (sys_rst) begin
      pace <= 2'h0;
      tx_ready <= 1'b0;
      ncap <= 0;
    end else begin
      pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      tx_ready <= stall ? (pace == 2'h2) : 1'b1;
      if (tx_word.valid && tx_ready) begin
        cap[ncap] <= tx_word.data;
        ncap <= ncap + 1;
      end
    end
  end
  // source: whole payload, then the data lines show the inverse, never stale
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_word <= '{1'b1, i == n - 1, rxbuf[i]};
    end
    @(posedge clk);
    rx_word <= '{1'b0, 1'b0, ~rx_word.data};
  endtask
endmodule // remote_port
`default_nettype wire

// ---- test/login_service_param_codec_test.sv ----
// self-checking bench for the login parameter codec
`timescale 1ns/1ns
`default_nettype none
module login_service_param_codec_test;
  import login_pkg::*;
  logic clk;
  logic sys_rst;
  apb_req_s apb_req;
  apb_rsp_s apb_rsp;
  word_s tx_word;
  word_s rx_word;
  logic tx_ready;
  logic irq;
  logic stall;
  int mismatches;
  int checks;
  logic [31:0] rd;
  logic err;
  localparam logic [63:0] PN = 64'h2000_1111_2222_3333;
  localparam logic [63:0] NN = 64'h1000_4444_5555_6666;
  localparam logic [63:0] FN = 64'h5000_7777_8888_9999;

  login_param_codec login_param_codec_i (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .tx_word(tx_word), .tx_ready(tx_ready), .rx_word(rx_word), .irq(irq));
  remote_port remote_port_i (.clk(clk), .sys_rst(sys_rst), .tx_word(tx_word), .tx_ready(tx_ready),
    .rx_word(rx_word), .stall(stall));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp({31'h0, got}, {31'h0, exp}, what);
  endtask

  // apb transfer; answer taken at the rising edge that sees pready, released right there
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1);
    cmp(n, 32'h0000_0002, "apb wait states");
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp(rd, 32'h0, "status at reset");
    apb(1'b0, OFS_EFF, 32'h0);
    cmp(rd & 32'h6, 32'h0, "class valid before login");
    cmp_bit(irq, 1'b0, "irq at reset");
    apb(1'b0, 8'h80, 32'h0);
    cmp_bit(err, 1'b1, "unmapped error");
    cmp(rd, 32'h0, "unmapped read");
  endtask

  task automatic cfg();
    wr(OFS_BB, 32'h0000_3800);
    wr(OFS_SEQ, 32'h0014_4004);
    wr(OFS_RATOV, 32'h0000_000a);
    wr(OFS_EDTOV, 32'h0000_07d0);
    wr(OFS_REQ_EDTOV, 32'h0000_0bb8);
    wr(OFS_PNAME_HI, PN[63:32]);
    wr(OFS_PNAME_LO, PN[31:0]);
    wr(OFS_NNAME_HI, NN[63:32]);
    wr(OFS_NNAME_LO, NN[31:0]);
    wr(OFS_FNAME_HI, FN[63:32]);
    wr(OFS_FNAME_LO, FN[31:0]);
    wr(OFS_CONC, 32'h0000_0b0a);
    wr(OFS_EXTLEN, 32'h0000_0002);
    wr(OFS_MASK, 32'h0000_0007);
  endtask

  // one outgoing payload, judged by word count and words 1-8, 13, 16, 17 and 20 against the register values
  task automatic tx_case(input logic [7:0] ctrl, input int len, input logic flag, input logic [31:0] w4,
      input logic [63:0] name);
    int b;
    int n;
    b = remote_port_i.ncap;
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, {24'h0, ctrl | 8'h01});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_TX_DONE] !== 1'b1 && n < 200);
    cmp_bit(rd[ST_TX_DONE], 1'b1, "tx done");
    cmp(remote_port_i.ncap - b, len, "word count");
    cmp(remote_port_i.cap[b+1], {5'h0, ctrl[5], ctrl[4], 8'h0, flag, 16'h3800}, "w1");
    cmp(remote_port_i.cap[b+2], 32'h0014_4004, "w2");
    cmp(remote_port_i.cap[b+3], 32'h0000_000a, "ratov");
    cmp(remote_port_i.cap[b+4], w4, "edtov");
    cmp(remote_port_i.cap[b+5], PN[63:32], "pname hi");
    cmp(remote_port_i.cap[b+6], PN[31:0], "pname lo");
    cmp(remote_port_i.cap[b+7], name[63:32], "name hi");
    cmp(remote_port_i.cap[b+8], name[31:0], "name lo");
    cmp(remote_port_i.cap[b+13], 32'h8000_0000, "cls2 w0");
    cmp(remote_port_i.cap[b+16], 32'h000a_0000, "cls2 conc");
    cmp(remote_port_i.cap[b+17], 32'h8000_0000, "cls3 w0");
    cmp(remote_port_i.cap[b+20], 32'h000b_0000, "cls3 conc");
    apb(1'b0, OFS_EFF_EDTOV, 32'h0);
    if (ctrl[CT_ACCEPT]) cmp(rd, w4, "eff edtov on accept");
  endtask

  // one incoming payload; status settles at the edge that takes the last word
  task automatic rx_case(input logic [31:0] w1, input int n, input logic [31:0] w4, input logic perr);
    for (int i = 0; i < n; i++) remote_port_i.rxbuf[i] = 32'h0;
    remote_port_i.rxbuf[1] = w1;
    remote_port_i.rxbuf[4] = w4;
    remote_port_i.rxbuf[13] = 32'h8000_0000;
    remote_port_i.rxbuf[17] = 32'h8000_0000;
    wr(OFS_STATUS, 32'h7);
    remote_port_i.send(n);
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b1, "irq on rx");
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp(rd, {29'h0, perr, 2'b10}, "rx status");
    apb(1'b0, OFS_RX_W1, 32'h0);
    cmp(rd, w1, "rx w1");
  endtask

  // mask hides the pending event, unmask shows it, w1c clears it
  task automatic t_irq();
    wr(OFS_MASK, 32'h0);
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b0, "irq masked");
    wr(OFS_MASK, 32'h7);
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b1, "irq unmasked");
    wr(OFS_STATUS, 32'h7);
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b0, "irq cleared");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog well beyond the fewer than one thousand cycles the run needs
  initial begin
    #500000;
    mismatches++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    apb_req = '0;
    stall = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    cfg();
    tx_case(8'h30, 29, 1'b0, 32'h0000_07d0, NN);
    stall <= 1'b1;
    tx_case(8'h0e, 66, 1'b1, 32'h0000_0bb8, FN);
    tx_case(8'h46, 29, 1'b0, 32'h0000_0bb8, NN);
    stall <= 1'b0;
    rx_case(32'h0000_0800, 29, 32'h0, 1'b0);
    rx_case(32'h0000_00fc, 29, 32'h0, 1'b1);
    rx_case(32'h0000_0100, 29, 32'h0, 1'b0);
    rx_case(32'h0000_0840, 29, 32'h0, 1'b0);
    rx_case(32'h0000_0844, 29, 32'h0, 1'b1);
    rx_case(32'h0000_0802, 29, 32'h0, 1'b1);
    rx_case(32'h0000_0800, 28, 32'h0, 1'b1);
    wr(OFS_CTRL, 32'h0);
    rx_case(32'h0000_0800, 29, 32'h0000_07cf, 1'b1);
    rx_case(32'h0000_0800, 29, 32'h0000_07d0, 1'b0);
    t_irq();
    apb(1'b0, OFS_EFF_EDTOV, 32'h0);
    cmp(rd, 32'h0000_07d0, "eff edtov adopted");
    apb(1'b0, OFS_EFF, 32'h0);
    cmp(rd & 32'h0000_0006, 32'h0, "class defaults before login");
    wr(OFS_CTRL, 32'h0000_0080);
    apb(1'b0, OFS_EFF, 32'h0);
    cmp(rd & 32'h0000_0006, 32'h0000_0006, "class valid after login");
    conclude();
  end
endmodule // login_service_param_codec_test
`default_nettype wire
